// ### hdl/rsc_defines.vh
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
// Register indexes; byte address is four times the index
`define RSC_IDX_POST_TX        8'h17
`define RSC_IDX_CAL_TIMEOUT    8'h18
`define RSC_ADDR_POST_TX       10'h05C
`define RSC_ADDR_CAL_TIMEOUT   10'h060
// Field positions
`define RSC_POSTTX_LSB         0
`define RSC_POSTTX_MSB         1
`define RSC_WAIT_LSB           2
`define RSC_WAIT_MSB           3
`define RSC_AUTOCAL_LSB        4
`define RSC_AUTOCAL_MSB        5
// Reset values
`define RSC_POSTTX_RST         2'h0
`define RSC_AUTOCAL_RST        2'h0
`define RSC_WAIT_RST           2'h2
// Post-transmit codes
`define RSC_NEXT_IDLE          2'h0
`define RSC_NEXT_SYNTH_ON      2'h1
`define RSC_NEXT_STAY_TX       2'h2
`define RSC_NEXT_RX_UNUSED     2'h3
// Auto-calibration codes
`define RSC_CAL_NEVER          2'h0
`define RSC_CAL_ENTER_TX       2'h1
`define RSC_CAL_LEAVE_TX       2'h2
`define RSC_CAL_EVERY_FOURTH   2'h3
// Power-on wait expire counts
`define RSC_EXPIRE_0           9'h001
`define RSC_EXPIRE_1           9'h010
`define RSC_EXPIRE_2           9'h040
`define RSC_EXPIRE_3           9'h100
`define RSC_RIPPLE_MAX         6'h3F
`endif

// ### hdl/rsc_radio_state_config.v
// Functional notes
// RULE1: After a sent packet the next state is idle for post-transmit code 0 and synth-on-ready for code 1.
// RULE2: For post-transmit code 2 the radio stays in transmit and restarts preamble after a packet.
// RULE3: Software must never write post-transmit code 3, the unimplemented go-to-receive choice.
// RULE4: Auto-calibration code 1 calibrates when leaving idle for transmit or synth-on, code 2 on transmit to idle; code 1 uses idle_to_tx only.
// RULE5: Auto-calibration code 0 never calibrates by itself; only the manual calibrate strobe calibrates.
// RULE6: Auto-calibration code 3 calibrates on every fourth transmit-to-idle move, counted in hardware.
// RULE7: After oscillator start a six-bit ripple counter must expire the selected number of times before ready goes low.
// RULE8: Power-on wait codes 0 to 3 give 1, 16, 64 and 256 expiries, with code 2 after reset.
// RULE9: With the oscillator kept on in power-down, software should pick a wait long enough for the supply, code 2.
// RULE10: With the oscillator off in power-down, software may pick code 0, though code 2 stays the safer choice.
// RULE11: The power-on wait field keeps its value through sleep power-down.
// RULE12: Reserved bits of both registers read as zero and ignore writes.
`include "rsc_defines.vh"
`default_nettype none
module rsc_radio_state_config #(
   parameter RIPPLE_BITS = 6
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        packet_sent,
   input  wire        idle_to_tx,
   input  wire        tx_to_idle,
   input  wire        manual_calibrate_strobe,
   input  wire        xosc_running,
   output reg  [1:0]  post_transmit_next_state,
   output reg         post_transmit_valid,
   output reg         calibrate_start,
   output reg         chip_ready_active_low
);
   // Ripple counter constants
   localparam [RIPPLE_BITS-1:0] RIPPLE_ZERO = {RIPPLE_BITS{1'b0}};
   localparam [RIPPLE_BITS-1:0] RIPPLE_ONE  = {{(RIPPLE_BITS-1){1'b0}}, 1'b1};
   localparam [RIPPLE_BITS-1:0] RIPPLE_MAX  = {RIPPLE_BITS{1'b1}};

   reg  [1:0]             post_tx_sel_r;
   reg  [1:0]             auto_calibration_select;
   reg  [1:0]             power_on_wait_select;
   reg                    wr_pend_r;
   reg  [9:0]             wr_addr_r;
   reg  [1:0]             fourth_cnt_r;
   reg  [RIPPLE_BITS-1:0] ripple_r;
   reg  [8:0]             expire_r;
   reg  [8:0]             expire_target;
   reg  [31:0]            rd_nxt;
   reg                    cal_nxt;
   wire                   addr_ok;
   wire                   ripple_wrap;
   wire                   wr_post_tx;
   wire                   wr_cal_timeout;
   wire                   fourth_due;

   assign addr_ok        = hsel && hready && htrans[1];
   assign ripple_wrap    = (ripple_r == RIPPLE_MAX);
   assign wr_post_tx     = wr_pend_r && (wr_addr_r == `RSC_ADDR_POST_TX);
   assign wr_cal_timeout = wr_pend_r && (wr_addr_r == `RSC_ADDR_CAL_TIMEOUT);
   assign fourth_due     = (fourth_cnt_r == 2'h3);

   // Read value of the addressed register
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (haddr[9:0])
         `RSC_ADDR_POST_TX: begin
            rd_nxt[`RSC_POSTTX_MSB:`RSC_POSTTX_LSB] = post_tx_sel_r; // see RULE12
         end
         `RSC_ADDR_CAL_TIMEOUT: begin
            rd_nxt[`RSC_AUTOCAL_MSB:`RSC_AUTOCAL_LSB] = auto_calibration_select; // see RULE12
            rd_nxt[`RSC_WAIT_MSB:`RSC_WAIT_LSB]       = power_on_wait_select;
         end
         default: begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   // Bus slave: zero wait states, always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Address phase capture and read data
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 10'h000;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_r <= haddr[9:0];
            hrdata    <= hwrite ? 32'h0000_0000 : rd_nxt;
         end
      end
   end

   // Configuration storage; reset only by hresetn, so sleep keeps it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         post_tx_sel_r <= `RSC_POSTTX_RST;
      end else if (wr_post_tx) begin
         post_tx_sel_r <= hwdata[`RSC_POSTTX_MSB:`RSC_POSTTX_LSB]; // see RULE12
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         auto_calibration_select <= `RSC_AUTOCAL_RST;
         power_on_wait_select    <= `RSC_WAIT_RST; // see RULE8
      end else if (wr_cal_timeout) begin
         auto_calibration_select <= hwdata[`RSC_AUTOCAL_MSB:`RSC_AUTOCAL_LSB];
         power_on_wait_select    <= hwdata[`RSC_WAIT_MSB:`RSC_WAIT_LSB]; // see RULE11
      end
   end

   // Next state after a sent packet
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         post_transmit_next_state <= `RSC_NEXT_IDLE;
         post_transmit_valid      <= 1'b0;
      end else begin
         post_transmit_valid <= packet_sent;
         if (packet_sent) begin
            case (post_tx_sel_r)
               `RSC_NEXT_IDLE: begin
                  post_transmit_next_state <= `RSC_NEXT_IDLE; // see RULE1
               end
               `RSC_NEXT_SYNTH_ON: begin
                  post_transmit_next_state <= `RSC_NEXT_SYNTH_ON; // see RULE1
               end
               `RSC_NEXT_STAY_TX: begin
                  post_transmit_next_state <= `RSC_NEXT_STAY_TX; // see RULE2
               end
               default: begin
                  post_transmit_next_state <= `RSC_NEXT_IDLE; // see RULE3
               end
            endcase
         end
      end
   end

   // Calibration trigger
   always @* begin
      case (auto_calibration_select)
         `RSC_CAL_ENTER_TX: begin
            cal_nxt = idle_to_tx; // see RULE4
         end
         `RSC_CAL_LEAVE_TX: begin
            cal_nxt = tx_to_idle; // see RULE4
         end
         `RSC_CAL_EVERY_FOURTH: begin
            cal_nxt = tx_to_idle && fourth_due; // see RULE6
         end
         default: begin
            cal_nxt = 1'b0; // see RULE5
         end
      endcase
   end

   // Calibration start pulse
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         calibrate_start <= 1'b0;
      end else begin
         calibrate_start <= cal_nxt || manual_calibrate_strobe; // see RULE5
      end
   end

   // Count of transmit-to-idle moves, running in every mode
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fourth_cnt_r <= 2'h0;
      end else if (tx_to_idle) begin
         fourth_cnt_r <= fourth_cnt_r + 2'h1; // see RULE6
      end
   end

   // Power-on wait after oscillator start
   always @* begin
      case (power_on_wait_select)
         2'h0: begin
            expire_target = `RSC_EXPIRE_0; // see RULE8
         end
         2'h1: begin
            expire_target = `RSC_EXPIRE_1;
         end
         2'h2: begin
            expire_target = `RSC_EXPIRE_2;
         end
         default: begin
            expire_target = `RSC_EXPIRE_3;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ripple_r              <= RIPPLE_ZERO;
         expire_r              <= 9'h000;
         chip_ready_active_low <= 1'b1;
      end else if (!xosc_running) begin
         ripple_r              <= RIPPLE_ZERO;
         expire_r              <= 9'h000;
         chip_ready_active_low <= 1'b1;
      end else if (chip_ready_active_low) begin
         ripple_r <= ripple_r + RIPPLE_ONE; // see RULE7
         if (ripple_wrap) begin
            expire_r <= expire_r + 9'h001;
            if (expire_r + 9'h001 >= expire_target)
               chip_ready_active_low <= 1'b0; // see RULE7
         end
      end
   end
endmodule // rsc_radio_state_config
`default_nettype wire

// ### verification/rsc_radio_state_config_properties.sv
`default_nettype none
module rsc_radio_state_config_properties (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       packet_sent,
   input wire logic       idle_to_tx,
   input wire logic       tx_to_idle,
   input wire logic       manual_calibrate_strobe,
   input wire logic       xosc_running,
   input wire logic [1:0] post_transmit_next_state,
   input wire logic       post_transmit_valid,
   input wire logic       calibrate_start,
   input wire logic       chip_ready_active_low
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_vld; packet_sent |=> post_transmit_valid; endproperty
   a_vld: assert property (p_vld) else $error("valid missing");
   property p_novld; !packet_sent |=> !post_transmit_valid; endproperty
   a_novld: assert property (p_novld) else $error("stray valid");
   property p_code; post_transmit_valid |-> post_transmit_next_state != 2'h3; endproperty
   a_code: assert property (p_code) else $error("bad next state");
   property p_hold; !packet_sent |=> $stable(post_transmit_next_state); endproperty
   a_hold: assert property (p_hold) else $error("next state moved");
   property p_man; manual_calibrate_strobe |=> calibrate_start; endproperty
   a_man: assert property (p_man) else $error("manual cal missing");
   property p_nocal; !(idle_to_tx || tx_to_idle || manual_calibrate_strobe) |=> !calibrate_start; endproperty
   a_nocal: assert property (p_nocal) else $error("stray cal");
   property p_off; !xosc_running |=> chip_ready_active_low; endproperty
   a_off: assert property (p_off) else $error("ready without osc");
   property p_wait; $fell(chip_ready_active_low) |-> $past(xosc_running, 60); endproperty
   a_wait: assert property (p_wait) else $error("ready too early");
endmodule // rsc_radio_state_config_properties
`default_nettype wire

// ### verification/rsc_host_model.sv
`default_nettype none
module rsc_host_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
endmodule // rsc_host_model
`default_nettype wire

// ### verification/test_radio_state_control_config.sv
`default_nettype none
module test_radio_state_control_config;
   timeunit 1ns;
   timeprecision 100ps;
   logic        hclk = 0, hresetn = 0, xosc = 0, hsel, hwrite, hreadyout, hresp, vld, cal, rdy_n;
   logic [2:0]  hsize;
   logic [3:0]  ev = 0;
   logic [1:0]  htrans, nst;
   logic [31:0] haddr, hwdata, hrdata, q;
   int          failures = 0, compares = 0, cyc = 0, txi = 0, n[4] = '{1, 16, 64, 256};
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; $display("MISMATCH t=%0t %h %h", $time, a, e); end end
   always #12.5 hclk = ~hclk;
   rsc_host_model rsc_host_model_inst (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata);
   rsc_radio_state_config rsc_radio_state_config_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .packet_sent(ev[3]),
      .idle_to_tx(ev[2]), .tx_to_idle(ev[1]), .manual_calibrate_strobe(ev[0]), .xosc_running(xosc),
      .post_transmit_next_state(nst), .post_transmit_valid(vld), .calibrate_start(cal), .chip_ready_active_low(rdy_n));
   task print_verdict;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task pulse(input logic [3:0] v);
      @(posedge hclk);
      ev <= v;
      @(posedge hclk);
      ev <= 4'h0;
      #1;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         print_verdict;
      end
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rsc_host_model_inst.xfer(1, 32'h64, 32'hFFFFFFFF, q);
      rsc_host_model_inst.xfer(0, 32'h64, 0, q);
      `CHK(q, 32'h0)
      `CHK({hreadyout, hresp}, 2'h2)
      rsc_host_model_inst.xfer(0, 32'h5C, 0, q);
      `CHK(q, 32'h0)
      rsc_host_model_inst.xfer(0, 32'h60, 0, q);
      `CHK(q, 32'h8)
      rsc_host_model_inst.xfer(1, 32'h5C, 32'hFFFFFFFE, q);
      rsc_host_model_inst.xfer(0, 32'h5C, 0, q);
      `CHK(q, 32'h2)
      for (int m = 0; m < 3; m++) begin
         rsc_host_model_inst.xfer(1, 32'h5C, m, q);
         pulse(4'h8);
         `CHK({vld, nst}, {1'b1, m[1:0]})
      end
      for (int m = 0; m < 4; m++) begin
         rsc_host_model_inst.xfer(1, 32'h60, {24'hFFFFFF, 2'h3, m[1:0], 4'hB}, q);
         rsc_host_model_inst.xfer(0, 32'h60, 0, q);
         `CHK(q, {26'h0, m[1:0], 4'h8})
         pulse(4'h4);
         `CHK(cal, m == 1)
         repeat (4) begin
            pulse(4'h2);
            `CHK(cal, m == 2 || (m == 3 && txi % 4 == 3))
            txi++;
         end
         pulse(4'h1);
         `CHK(cal, 1'b1)
      end
      for (int w = 0; w < 4; w++) begin
         @(posedge hclk) xosc <= 1'b0;
         rsc_host_model_inst.xfer(1, 32'h60, w << 2, q);
         xosc <= 1'b1;
         repeat (64 * n[w] - 1) @(posedge hclk);
         #1 `CHK(rdy_n, 1'b1)
         @(posedge hclk);
         #1 `CHK(rdy_n, 1'b0)
      end
      @(posedge hclk) xosc <= 1'b0;
      rsc_host_model_inst.xfer(0, 32'h60, 0, q);
      `CHK(q, 32'hC)
      print_verdict;
   end
endmodule // test_radio_state_control_config
bind rsc_radio_state_config rsc_radio_state_config_properties rsc_radio_state_config_properties_inst (.*);
`default_nettype wire
